//--- rtl/luma_adjust_consts.svh
/*
  Register indices, field positions, reset values and fixed levels of the
  first-window luma adjustment stage.
  Assumes every includer wants plain `define constants.
*/
`ifndef LUMA_ADJUST_CONSTS_SVH
`define LUMA_ADJUST_CONSTS_SVH

// Register indices; the byte address is four times the index
`define IDX_SHARPEN_CORE 10'h126
`define IDX_LUMA_OFFSET 10'h127
`define IDX_LUMA_GAIN 10'h128
`define IDX_WIN_STATUS 10'h129

// Reset values
`define RST_SHARPEN_CORE 12'h000
`define RST_LUMA_OFFSET 12'h000
`define RST_LUMA_GAIN 12'h020

// Settings used outside the window: everything passes unchanged
`define NEUTRAL_SHARPEN 12'h0E0
`define NEUTRAL_GAIN 12'h640

// Fields of sharpen_core_select
`define F_CORE 1:0
`define F_PEAK 4:2
`define F_LP_SKIP 5
`define F_SKEW_SKIP 6
`define F_SKEW_VACT_SKIP 7
`define F_CHROMA_SWAP 8

// Fields of luma_offset_level and luma_gain_control
`define F_OFFSET 7:0
`define F_GAIN_LEVEL 5:0
`define F_DEPTH 7:6
`define F_BLACK_SEL 8
`define F_OFFSET_SKIP 9
`define F_GAIN_SKIP 10

// Fixed levels
`define BLACK_LEVEL_HI 9'h020
`define BLACK_LEVEL_LO 9'h010
`define OFFSET_BIAS 18'h0007F

`endif

//--- rtl/luma_adjust_pkg.sv
/*
  Types of the first-window luma adjustment stage: depth reduction modes
  and the state records of its three modules.
  Assumes nothing of its surroundings.
*/
package luma_adjust_pkg;
  typedef enum logic [1:0] {
    DEPTH_ROUND = 2'b00,
    DEPTH_TRUNC = 2'b01,
    DEPTH_ACC1 = 2'b10,
    DEPTH_ACC2 = 2'b11
  } depth_mode_t;

  // Tap layout: [18] window, [17] first of pair, [16] vact, [15:8] c, [7:0] y
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [11:0] sh_sharpen;
    logic [11:0] sh_offset;
    logic [11:0] sh_gain;
    logic [11:0] ap_sharpen;
    logic [11:0] ap_offset;
    logic [11:0] ap_gain;
    logic phase;
    logic [18:0] t0;
    logic [18:0] t1;
    logic [18:0] t2;
    logic sv;
    logic [18:0] s1;
    logic [18:0] s1p;
    logic ovalid;
    logic [7:0] oy;
    logic [7:0] oc;
    logic ovact;
  } main_state_t;

  typedef struct packed {
    logic [17:0] a;
    logic [17:0] b;
    logic [17:0] c;
    logic ov;
    logic [17:0] od;
  } sharpen_state_t;

  typedef struct packed {
    logic [1:0] acc;
    logic ov;
    logic [17:0] od;
  } gain_state_t;
endpackage

//--- rtl/stage_if.sv
/*
  Sample stream between the stages: a valid pulse with one sample word.
  Assumes the word is {window, vact, c, y} and valid lasts one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface stage_if #(parameter int W = 18) ();
  logic valid;
  logic [W-1:0] data;
  modport src (output valid, output data);
  modport dst (input valid, input data);
endinterface
`default_nettype wire

//--- rtl/sharpen_stage.sv
/*
  Peaking with coring on a three-sample horizontal window of luma.
  Assumes samples arrive as valid pulses and carry their window flag.
*/
`timescale 1ns/1ps
`default_nettype none
`include "luma_adjust_consts.svh"
module sharpen_stage (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Settings
  input wire logic [11:0] cfg,
  // Stream
  stage_if.dst in_s,
  stage_if.src out_s
);
  luma_adjust_pkg::sharpen_state_t st, next_st;
  logic [11:0] eff;
  logic signed [10:0] hp;
  logic [10:0] neg;
  logic [9:0] mag;
  logic [2:0] amt;
  logic [9:0] cm;
  logic signed [10:0] cored;
  logic signed [14:0] prod;
  logic signed [11:0] sum;
  logic [7:0] sat;

  assign eff = st.b[17] ? cfg : `NEUTRAL_SHARPEN;
  assign hp = $signed({2'b00, st.b[7:0], 1'b0}) - $signed({3'b000, st.a[7:0]})
    - $signed({3'b000, st.c[7:0]});
  assign neg = -hp;
  assign mag = hp[10] ? neg[9:0] : hp[9:0];
  always_comb begin
    case (eff[`F_CORE])
      2'h0: amt = 3'h0;
      2'h1: amt = 3'h1;
      2'h2: amt = 3'h2;
      default: amt = 3'h4;
    endcase
  end
  // Detail is kept in half-LSB units so half an LSB can be cored away
  assign cm = (mag > {7'h00, amt}) ? mag - {7'h00, amt} : 10'h000;
  assign cored = hp[10] ? -$signed({1'b0, cm}) : $signed({1'b0, cm});
  assign prod = $signed({{4{cored[10]}}, cored}) * $signed({12'h000, eff[`F_PEAK]});
  assign sum = $signed({4'h0, st.b[7:0]}) + $signed({prod[14], prod[14:4]});
  assign sat = sum[11] ? 8'h00 : ((sum[10:8] != 3'h0) ? 8'hFF : sum[7:0]);

  always_comb begin
    next_st = st;
    next_st.ov = in_s.valid;
    if (in_s.valid) begin
      next_st.a = in_s.data;
      next_st.b = st.a;
      next_st.c = st.b;
      next_st.od = {st.b[17:8], sat};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_s.valid = st.ov;
  assign out_s.data = st.od;

  property p_no_peak;
    @(posedge clock) disable iff (!rst_n)
    in_s.valid && (eff[`F_PEAK] == 3'h0) |=> out_s.data[7:0] == $past(st.b[7:0]);
  endproperty
  a_no_peak: assert property (p_no_peak) else $error("peaking zero altered luma");

  property p_core_all;
    @(posedge clock) disable iff (!rst_n)
    in_s.valid && (eff[`F_CORE] == 2'h3) && (mag <= 10'h004)
      |=> out_s.data[7:0] == $past(st.b[7:0]);
  endproperty
  a_core_all: assert property (p_core_all) else $error("small detail survived coring");
endmodule // sharpen_stage
`default_nettype wire

//--- rtl/gain_stage.sv
/*
  Contrast gain, brightness offset and reduction to 8 bits of luma.
  Assumes samples arrive as valid pulses and carry their window flag.
*/
`timescale 1ns/1ps
`default_nettype none
`include "luma_adjust_consts.svh"
module gain_stage (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Settings
  input wire logic [11:0] offset_cfg,
  input wire logic [11:0] gain_cfg,
  // Stream
  stage_if.dst in_s,
  stage_if.src out_s
);
  luma_adjust_pkg::gain_state_t st, next_st;
  logic [11:0] g;
  logic [8:0] blk;
  logic signed [17:0] v, m, off, r, r9, r10, s, q;
  logic [1:0] nacc;
  logic [7:0] sat;

  assign g = in_s.data[17] ? gain_cfg : `NEUTRAL_GAIN;
  assign blk = g[`F_BLACK_SEL] ? `BLACK_LEVEL_LO : `BLACK_LEVEL_HI;
  // Black level out, gain, black level back, offset, then width cut
  assign v = $signed({10'h000, in_s.data[7:0]}) - $signed({9'h000, blk});
  assign m = g[`F_GAIN_SKIP] ? (v <<< 5) : v * $signed({12'h000, g[`F_GAIN_LEVEL]});
  assign off = g[`F_OFFSET_SKIP] ? 18'h00000
    : ($signed({10'h000, offset_cfg[`F_OFFSET]}) - $signed(`OFFSET_BIAS)) <<< 5;
  assign r = m + ($signed({9'h000, blk}) <<< 5) + off;
  assign r10 = r >>> 3;
  assign r9 = r >>> 4;

  always_comb begin
    s = 18'h00000;
    nacc = st.acc;
    case (luma_adjust_pkg::depth_mode_t'(g[`F_DEPTH]))
      // Signed constant keeps the shift arithmetic, so dark results clip to zero
      luma_adjust_pkg::DEPTH_ROUND: q = (r9 + 18'sh00001) >>> 1;
      luma_adjust_pkg::DEPTH_TRUNC: q = r9 >>> 1;
      luma_adjust_pkg::DEPTH_ACC1: begin
        s = r9 + {17'h00000, st.acc[0]};
        q = s >>> 1;
        nacc = {1'b0, s[0]};
      end
      default: begin
        s = r10 + {16'h0000, st.acc};
        q = s >>> 2;
        nacc = s[1:0];
      end
    endcase
  end
  assign sat = q[17] ? 8'h00 : ((q[16:8] != 9'h000) ? 8'hFF : q[7:0]);

  always_comb begin
    next_st = st;
    next_st.ov = in_s.valid;
    if (in_s.valid) begin
      next_st.acc = nacc;
      next_st.od = {in_s.data[17:8], sat};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_s.valid = st.ov;
  assign out_s.data = st.od;

  property p_both_skip;
    @(posedge clock) disable iff (!rst_n)
    in_s.valid && g[`F_GAIN_SKIP] && g[`F_OFFSET_SKIP] && (g[`F_DEPTH] == 2'h1)
      |=> out_s.data[7:0] == $past(in_s.data[7:0]);
  endproperty
  a_both_skip: assert property (p_both_skip) else $error("skipped stages altered luma");

  property p_gain_one;
    @(posedge clock) disable iff (!rst_n)
    in_s.valid && !g[`F_GAIN_SKIP] && (g[`F_GAIN_LEVEL] == 6'h20) && g[`F_OFFSET_SKIP]
      && (g[`F_DEPTH] == 2'h1) |=> out_s.data[7:0] == $past(in_s.data[7:0]);
  endproperty
  a_gain_one: assert property (p_gain_one) else $error("unity gain altered luma");

  property p_offset_low;
    @(posedge clock) disable iff (!rst_n)
    in_s.valid && g[`F_GAIN_SKIP] && !g[`F_OFFSET_SKIP] && (offset_cfg[7:0] == 8'h00)
      && (g[`F_DEPTH] == 2'h1) && (in_s.data[7:0] >= 8'h7F)
      |=> out_s.data[7:0] == $past(in_s.data[7:0]) - 8'h7F;
  endproperty
  a_offset_low: assert property (p_offset_low) else $error("offset code 0 not minus 127");

  property p_black;
    @(posedge clock) disable iff (!rst_n)
    in_s.valid && !g[`F_GAIN_SKIP] && (g[`F_GAIN_LEVEL] == 6'h00) && g[`F_OFFSET_SKIP]
      && (g[`F_DEPTH] == 2'h1) |=> out_s.data[7:0] == ($past(g[8]) ? 8'h10 : 8'h20);
  endproperty
  a_black: assert property (p_black) else $error("zero gain not at black level");
endmodule // gain_stage
`default_nettype wire

//--- rtl/video_luma_adjust_window1.sv
/*
  First-window luma and chroma adjustment: lowpass, skew filter, chroma
  order, peaking with coring, contrast, brightness and width reduction,
  with its three settings words on a classic Wishbone slave.
  Assumes one clock, a pixel stream of valid pulses with y and
  multiplexed Cb/Cr, and a window flag from the window logic upstream.
*/
`timescale 1ns/1ps
`default_nettype none
`include "luma_adjust_consts.svh"
module video_luma_adjust_window1 (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pixel stream in
  input wire logic pix_valid,
  input wire logic [7:0] pix_y,
  input wire logic [7:0] pix_c,
  input wire logic pix_vact,
  input wire logic win1_active,
  // Pixel stream out
  output logic out_valid,
  output logic [7:0] out_y,
  output logic [7:0] out_c,
  output logic out_vact
);
  luma_adjust_pkg::main_state_t st, next_st;
  stage_if #(.W(18)) sh_in ();
  stage_if #(.W(18)) sh_out ();
  stage_if #(.W(18)) g_out ();

  logic bus_req;
  logic bus_wr;
  logic [9:0] idx;
  logic pending;
  logic [11:0] tc;
  logic [11:0] kc;
  logic [9:0] lp_sum;
  logic [7:0] lp;
  logic [7:0] c_sel;
  logic [8:0] sk_sum;
  logic [7:0] sk_y;
  logic sk_vact;

  // Reserved upper bits are stored as written; software keeps them zero
  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] d,
      input logic [3:0] sel);
    logic [11:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = d[7:0];
    end
    if (sel[1]) begin
      res[11:8] = d[11:8];
    end
    return res;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i;
  // Writes land at the edge where the master sees ack, never earlier
  assign bus_wr = bus_req && st.ack && wb_we_i;
  assign idx = wb_adr_i[11:2];
  assign pending = (st.sh_sharpen != st.ap_sharpen) || (st.sh_offset != st.ap_offset)
    || (st.sh_gain != st.ap_gain);

  // Settings of the sample at the lowpass tap and at the skew tap
  assign tc = st.t1[18] ? st.ap_sharpen : `NEUTRAL_SHARPEN;
  assign kc = st.s1[18] ? st.ap_sharpen : `NEUTRAL_SHARPEN;

  // Lowpass 1-2-1 with rounding
  assign lp_sum = {2'b00, st.t0[7:0]} + {1'b0, st.t1[7:0], 1'b0} + {2'b00, st.t2[7:0]}
    + 10'h002;
  assign lp = tc[`F_LP_SKIP] ? st.t1[7:0] : lp_sum[9:2];

  // The partner of a first sample is the newer tap, of a second the older
  assign c_sel = !tc[`F_CHROMA_SWAP] ? st.t1[15:8]
    : (st.t1[17] ? st.t0[15:8] : st.t2[15:8]);

  // Skew filter: half-sample interpolation between neighbours
  assign sk_sum = {1'b0, st.s1[7:0]} + {1'b0, st.s1p[7:0]} + 9'h001;
  assign sk_y = kc[`F_SKEW_SKIP] ? st.s1[7:0] : sk_sum[8:1];
  // Vact is held back one sample to match the interpolation delay
  assign sk_vact = kc[`F_SKEW_VACT_SKIP] ? st.s1[16] : st.s1p[16];

  assign sh_in.valid = st.sv;
  assign sh_in.data = {st.s1[18], sk_vact, st.s1[15:8], sk_y};

  always_comb begin
    next_st = st;
    next_st.ack = bus_req && !st.ack;
    if (bus_req && !st.ack) begin
      if (idx == `IDX_SHARPEN_CORE) begin
        next_st.dat = {20'h00000, st.sh_sharpen};
      end else if (idx == `IDX_LUMA_OFFSET) begin
        next_st.dat = {20'h00000, st.sh_offset};
      end else if (idx == `IDX_LUMA_GAIN) begin
        next_st.dat = {20'h00000, st.sh_gain};
      end else if (idx == `IDX_WIN_STATUS) begin
        next_st.dat = {30'h00000000, pending, win1_active};
      end else begin
        next_st.dat = 32'h00000000;
      end
    end
    if (bus_wr) begin
      if (idx == `IDX_SHARPEN_CORE) begin
        next_st.sh_sharpen = merge12(st.sh_sharpen, wb_dat_i, wb_sel_i);
      end else if (idx == `IDX_LUMA_OFFSET) begin
        next_st.sh_offset = merge12(st.sh_offset, wb_dat_i, wb_sel_i);
      end else if (idx == `IDX_LUMA_GAIN) begin
        next_st.sh_gain = merge12(st.sh_gain, wb_dat_i, wb_sel_i);
      end
    end
    // Settings change only between windows; window samples still in the pipeline when it closes take the new set
    if (!win1_active) begin
      next_st.ap_sharpen = st.sh_sharpen;
      next_st.ap_offset = st.sh_offset;
      next_st.ap_gain = st.sh_gain;
    end
    next_st.sv = pix_valid;
    if (pix_valid) begin
      next_st.t0 = {win1_active, st.phase, pix_vact, pix_c, pix_y};
      next_st.t1 = st.t0;
      next_st.t2 = st.t1;
      // The chroma pairing restarts with every active line
      next_st.phase = pix_vact ? !st.phase : 1'b1;
      next_st.s1 = {st.t1[18:16], c_sel, lp};
      next_st.s1p = st.s1;
    end
    next_st.ovalid = g_out.valid;
    if (g_out.valid) begin
      next_st.oy = g_out.data[7:0];
      next_st.oc = g_out.data[15:8];
      next_st.ovact = g_out.data[16];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.phase <= 1'b1;
      st.sh_sharpen <= `RST_SHARPEN_CORE;
      st.sh_offset <= `RST_LUMA_OFFSET;
      st.sh_gain <= `RST_LUMA_GAIN;
      st.ap_sharpen <= `RST_SHARPEN_CORE;
      st.ap_offset <= `RST_LUMA_OFFSET;
      st.ap_gain <= `RST_LUMA_GAIN;
    end else begin
      st <= next_st;
    end
  end

  sharpen_stage u_sharpen (
    .clock(clock),
    .rst_n(rst_n),
    .cfg(st.ap_sharpen),
    .in_s(sh_in.dst),
    .out_s(sh_out.src)
  );

  gain_stage u_gain (
    .clock(clock),
    .rst_n(rst_n),
    .offset_cfg(st.ap_offset),
    .gain_cfg(st.ap_gain),
    .in_s(sh_out.dst),
    .out_s(g_out.src)
  );

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign out_valid = st.ovalid;
  assign out_y = st.oy;
  assign out_c = st.oc;
  assign out_vact = st.ovact;

  property p_load_idle;
    @(posedge clock) disable iff (!rst_n)
    !win1_active |=> (st.ap_sharpen == $past(st.sh_sharpen))
      && (st.ap_gain == $past(st.sh_gain)) && (st.ap_offset == $past(st.sh_offset));
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("settings not loaded between windows");

  property p_hold_active;
    @(posedge clock) disable iff (!rst_n)
    win1_active && bus_wr |=> $stable(st.ap_sharpen) && $stable(st.ap_offset)
      && $stable(st.ap_gain);
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("settings changed inside window");

  property p_lp_skip;
    @(posedge clock) disable iff (!rst_n)
    pix_valid && st.t1[18] && st.ap_sharpen[`F_LP_SKIP] |=> st.s1[7:0] == $past(st.t1[7:0]);
  endproperty
  a_lp_skip: assert property (p_lp_skip) else $error("lowpass skip did not pass luma");

  sequence s_straight;
    pix_valid && win1_active && st.t1[18] && st.ap_sharpen[`F_LP_SKIP]
      && st.ap_sharpen[`F_SKEW_SKIP];
  endsequence

  property p_skew_skip;
    @(posedge clock) disable iff (!rst_n)
    s_straight |=> sh_in.valid && (sh_in.data[7:0] == $past(st.t1[7:0]));
  endproperty
  a_skew_skip: assert property (p_skew_skip) else $error("skew skip did not pass luma");

  property p_vact_comp;
    @(posedge clock) disable iff (!rst_n)
    pix_valid && win1_active && st.t1[18] && !st.ap_sharpen[`F_SKEW_VACT_SKIP]
      |=> sh_in.data[16] == $past(st.s1[16]);
  endproperty
  a_vact_comp: assert property (p_vact_comp) else $error("vact not delayed for skew");

  property p_swap;
    @(posedge clock) disable iff (!rst_n)
    pix_valid && st.t1[18] && st.ap_sharpen[`F_CHROMA_SWAP] && st.t1[17]
      |=> st.s1[15:8] == $past(st.t0[15:8]);
  endproperty
  a_swap: assert property (p_swap) else $error("chroma pair not swapped");
endmodule // video_luma_adjust_window1
`default_nettype wire

//--- tb/pixel_source.sv
/*
  Upstream pixel source model: one sample every cycle, flat or square luma,
  Cb/Cr pairs counted from each rise of vact.
  Assumes the bench changes its controls just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pixel_source (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic square,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  // Stream
  output logic pix_valid,
  output logic [7:0] pix_y,
  output logic [7:0] pix_c,
  output logic pix_vact
);
  logic [3:0] cnt;
  logic phase;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      phase <= 1'b0;
      pix_valid <= 1'b0;
      pix_y <= 8'h00;
      pix_c <= 8'h80;
      pix_vact <= 1'b0;
    end else begin
      // Eight samples per level so every filter tap sees a clean edge
      cnt <= cnt + 4'h1;
      pix_valid <= 1'b1;
      pix_y <= (square && cnt[3]) ? hi : lo;
      pix_vact <= run;
      // First active sample after blanking is the first of a pair
      phase <= run ? ~phase : 1'b0;
      pix_c <= !run ? 8'h80 : (phase ? 8'hC0 : 8'h40);
    end
  end
endmodule // pixel_source
`default_nettype wire

//--- tb/video_luma_adjust_window1_tb.sv
/*
  Self-checking bench of the first-window luma adjustment stage.
  Assumes the pixel source model upstream and a Wishbone master here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "luma_adjust_consts.svh"
module video_luma_adjust_window1_tb;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic pix_valid, pix_vact, win1_active, out_valid, out_vact;
  logic [7:0] pix_y, pix_c, out_y, out_c;
  logic run, square, clr, mid, last_vact;
  logic [7:0] lo, hi, last_y, prev_y, maxy, miny, first_c;
  int mismatches, total_checks, cycles;
  localparam logic [11:0] A_SH = {`IDX_SHARPEN_CORE, 2'b00};
  localparam logic [11:0] A_OFF = {`IDX_LUMA_OFFSET, 2'b00};
  localparam logic [11:0] A_GAIN = {`IDX_LUMA_GAIN, 2'b00};

  video_luma_adjust_window1 u_video_luma_adjust_window1 (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pix_valid(pix_valid), .pix_y(pix_y), .pix_c(pix_c), .pix_vact(pix_vact),
    .win1_active(win1_active), .out_valid(out_valid), .out_y(out_y), .out_c(out_c),
    .out_vact(out_vact));
  pixel_source u_pixel_source (.clock(clock), .rst_n(rst_n), .run(run), .square(square),
    .lo(lo), .hi(hi), .pix_valid(pix_valid), .pix_y(pix_y), .pix_c(pix_c),
    .pix_vact(pix_vact));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Output statistics; cleared after the pipeline has settled
  always @(posedge clock) begin
    if (clr) begin
      mid <= 1'b0;
      maxy <= 8'h00;
      miny <= 8'hFF;
    end else if (out_valid === 1'b1) begin
      prev_y <= last_y;
      last_y <= out_y;
      last_vact <= out_vact;
      if (out_y > maxy) maxy <= out_y;
      if (out_y < miny) miny <= out_y;
      if (out_y > lo && out_y < hi) mid <= 1'b1;
      if (out_vact && !last_vact) first_c <= out_c;
    end
  end

  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; waits for ack, never assumes its latency
  task automatic wb_cycle(input logic we, input logic [11:0] a, input logic [11:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {20'h00000, d};
    wb_sel_i <= 4'hF;
    // Only the bench timeout ends a wait that never sees ack
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask

  // Settings load only outside the window, so the window is closed first
  task automatic set_regs(input logic [11:0] sh, input logic [11:0] off, input logic [11:0] g);
    win1_active <= 1'b0;
    run <= 1'b0;
    wb_cycle(1'b1, A_SH, sh);
    wb_cycle(1'b1, A_OFF, off);
    wb_cycle(1'b1, A_GAIN, g);
    repeat (3) @(posedge clock);
  endtask

  task automatic run_case(input logic sq, input logic [7:0] l, input logic [7:0] h);
    lo <= l;
    hi <= h;
    square <= sq;
    repeat (12) @(posedge clock);
    win1_active <= 1'b1;
    run <= 1'b1;
    repeat (14) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (40) @(posedge clock);
  endtask

  // Flat luma; acc modes dither, so a pair of outputs is summed instead
  task automatic flat(input logic [11:0] off, input logic [11:0] g, input logic [7:0] y,
                      input logic [8:0] exp, input logic pair);
    set_regs(12'h0E0, off, g);
    run_case(1'b0, y, y);
    check(pair ? {1'b0, prev_y} + {1'b0, last_y} : {1'b0, last_y}, exp);
  endtask

  task automatic t_regs();
    wb_cycle(1'b0, A_SH, 12'h000);
    check(q, 32'h00000000);
    wb_cycle(1'b0, A_OFF, 12'h000);
    check(q, 32'h00000000);
    wb_cycle(1'b0, A_GAIN, 12'h000);
    check(q, 32'h00000020);
    wb_cycle(1'b1, 12'h000, 12'h7FF);
    wb_cycle(1'b0, 12'h000, 12'h000);
    check(q, 32'h00000000);
    wb_cycle(1'b1, A_GAIN, 12'h7E1);
    wb_cycle(1'b0, A_GAIN, 12'h000);
    check(q, 32'h000007E1);
  endtask

  task automatic t_offset();
    flat(12'h08F, 12'h510, 8'h64, 9'h074, 1'b0);
    flat(12'h000, 12'h550, 8'hC8, 9'h049, 1'b0);
    flat(12'h0FF, 12'h510, 8'hFA, 9'h0FF, 1'b0);
    flat(12'h000, 12'h710, 8'hC8, 9'h0C8, 1'b0);
  endtask

  task automatic t_gain();
    flat(12'h000, 12'h310, 8'h74, 9'h042, 1'b0);
    flat(12'h000, 12'h210, 8'h74, 9'h04A, 1'b0);
    flat(12'h000, 12'h260, 8'hC8, 9'h0C8, 1'b0);
    flat(12'h000, 12'h340, 8'hC8, 9'h010, 1'b0);
  endtask

  // Gain 33/32 on 16 above black gives half an LSB to reduce
  task automatic t_depth();
    flat(12'h000, 12'h321, 8'h20, 9'h021, 1'b0);
    flat(12'h000, 12'h361, 8'h20, 9'h020, 1'b0);
    flat(12'h000, 12'h3A1, 8'h20, 9'h041, 1'b1);
    flat(12'h000, 12'h3E1, 8'h20, 9'h041, 1'b1);
  endtask

  task automatic t_swap();
    set_regs(12'h0E0, 12'h000, 12'h710);
    run_case(1'b0, 8'h64, 8'h64);
    check(first_c, 8'h40);
    set_regs(12'h1E0, 12'h000, 12'h710);
    run_case(1'b0, 8'h64, 8'h64);
    check(first_c, 8'hC0);
  endtask

  task automatic t_filters();
    set_regs(12'h040, 12'h000, 12'h710);
    run_case(1'b1, 8'h32, 8'h96);
    check(mid, 1'b1);
    set_regs(12'h0A0, 12'h000, 12'h710);
    run_case(1'b1, 8'h32, 8'h96);
    check(mid, 1'b1);
    set_regs(12'h0E0, 12'h000, 12'h710);
    run_case(1'b1, 8'h32, 8'h96);
    check({mid, maxy, miny}, {1'b0, 8'h96, 8'h32});
    set_regs(12'h0FC, 12'h000, 12'h710);
    run_case(1'b1, 8'h32, 8'h96);
    check(maxy > 8'h96, 1'b1);
    set_regs(12'h0FF, 12'h000, 12'h710);
    run_case(1'b1, 8'h64, 8'h65);
    check({maxy, miny}, {8'h65, 8'h64});
  endtask

  task automatic t_window();
    flat(12'h08F, 12'h510, 8'h64, 9'h074, 1'b0);
    wb_cycle(1'b1, A_OFF, 12'h000);
    repeat (20) @(posedge clock);
    check(last_y, 8'h74);
    win1_active <= 1'b0;
    repeat (20) @(posedge clock);
    check(last_y, 8'h64);
  endtask

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, win1_active, run, square, clr} = 8'h00;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    lo = 8'h00;
    hi = 8'h00;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_offset();
    t_gain();
    t_depth();
    t_swap();
    t_filters();
    t_window();
    stop_test();
  end
endmodule // video_luma_adjust_window1_tb
`default_nettype wire
